/* File: position_segment_sequencer_pkg.sv */
package position_segment_sequencer_pkg;

    // Bus and data sizes.
    localparam int DATA_W    = 32;
    localparam int ADDR_W    = 16;
    localparam int STRB_W    = 4;
    localparam int BYTE_W    = 8;
    localparam int SEG_BITS  = 5;
    localparam int SEG_COUNT = 31;

    // Segment table register indices and other register byte addresses; the byte address is the index shifted left by BYTE_SHIFT.
    localparam int                BYTE_SHIFT        = 2;
    localparam logic [ADDR_W-1:0] ALIGN_MASK        = 16'h0003;
    localparam logic [ADDR_W-1:0] CTRL_INDEX_FIRST  = 16'h0804;
    localparam logic [ADDR_W-1:0] VALUE_INDEX_FIRST = 16'h0806;
    localparam logic [ADDR_W-1:0] INDEX_LAST        = 16'h087e;
    localparam logic [ADDR_W-1:0] CMD_ADDR          = 16'h0000;
    localparam logic [ADDR_W-1:0] STATUS_ADDR       = 16'h0004;
    localparam logic [ADDR_W-1:0] TARGET_ADDR       = 16'h0008;

    // Control word layout.
    localparam int FIELD_W     = 4;
    localparam int TYPE_LSB    = 0;
    localparam int CMDTYPE_LSB = 4;
    localparam int INTR_BIT    = 8;
    localparam int OVLP_LSB    = 12;
    localparam int PROFILE_LSB = 16;
    localparam int PROFILE_W   = 16;

    localparam logic [FIELD_W-1:0] SEG_SINGLE  = 4'h0;
    localparam logic [FIELD_W-1:0] SEG_MULTI   = 4'h1;
    localparam logic [FIELD_W-1:0] SEG_SPEED   = 4'h2;
    localparam logic [FIELD_W-1:0] SEG_JUMP    = 4'h3;
    localparam logic [FIELD_W-1:0] CMD_ABS     = 4'h0;
    localparam logic [FIELD_W-1:0] CMD_INC     = 4'h1;
    localparam logic [FIELD_W-1:0] CMD_REL     = 4'h2;
    localparam logic [FIELD_W-1:0] SPEED_HOLD  = 4'h0;
    localparam logic [FIELD_W-1:0] SPEED_CHAIN = 4'h1;

    localparam logic [DATA_W-1:0]   CTRL_RESET  = 32'h00000000;
    localparam logic [DATA_W-1:0]   VALUE_RESET = 32'h00000000;
    localparam logic [SEG_BITS-1:0] HOME_SEG    = 5'h00;
    localparam logic [SEG_BITS-1:0] SEG_LAST    = 5'h1f;
    localparam logic [SEG_BITS-1:0] SEG_STEP    = 5'h01;

    // Command and status register fields.
    localparam int CMD_SEG_LSB  = 0;
    localparam int CMD_TRIG_BIT = 8;
    localparam int CMD_STOP_BIT = 9;
    localparam int ST_BUSY_BIT  = 0;
    localparam int ST_IDLE_BIT  = 1;
    localparam int ST_SEG_LSB   = 8;
    localparam int ST_STATE_LSB = 16;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [5:0] {
        S_IDLE  = 6'h01,
        S_FETCH = 6'h02,
        S_EXEC  = 6'h04,
        S_MOVE  = 6'h08,
        S_SPEED = 6'h10,
        S_HOME  = 6'h20
    } state_t;

    typedef enum logic [2:0] {
        REG_NONE   = 3'h0,
        REG_CMD    = 3'h1,
        REG_STATUS = 3'h2,
        REG_TARGET = 3'h3,
        REG_CTRL   = 3'h4,
        REG_VALUE  = 3'h5
    } region_t;

    typedef struct packed {
        region_t             kind;
        logic [SEG_BITS-1:0] seg;
    } decode_t;

endpackage

/* File: position_segment_sequencer.sv */
`timescale 1ns/1ps

// Notes on behaviour
// - 31 segments, word and value per index
// - Low half plans, high half selects profiles
// - Type 0 single, 1 multi, 2 speed, 3 jump
// - Single segment stops after completion
// - Multi segment starts following segment automatically
// - Speed segment holds speed until next start
// - Jump transfers execution to named segment
// - Command type 0: value is absolute target
// - Command type 2: measured position plus value
// - Command type 1: previous target plus value
// - Speed type 1 chains on speed reached
// - Interrupt field: 0 disabled, 1 enabled
// - Interrupt switches at once, carries remaining travel into a command type 2 target
// - Without interrupt, wait for motion completion; a running speed segment switches at once
// - Select segment, rising trigger starts it
// - Segment 0 triggers home return
module position_segment_sequencer
    import position_segment_sequencer_pkg::*;
(
    // Clock and reset.
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // Register bus write channels.
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic [2:0]        awprot,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic [STRB_W-1:0] wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // Register bus read channels.
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic [2:0]        arprot,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [DATA_W-1:0]      rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // Profile generator feedback.
    input  wire logic [DATA_W-1:0] measured_position,
    input  wire logic [DATA_W-1:0] remaining_travel,
    input  wire logic              motion_done,
    input  wire logic              speed_reached,
    // Profile generator commands.
    output logic [DATA_W-1:0]      target_position,
    output logic [DATA_W-1:0]      speed_value,
    output logic [PROFILE_W-1:0]   profile_select,
    output logic                   run_speed,
    output logic                   segment_start,
    output logic                   interrupt_switch,
    output logic                   home_request,
    output logic                   stop_request,
    output logic                   busy
);

    // Bus address decoding shared by the read and write paths.
    function automatic decode_t decode(input logic [ADDR_W-1:0] addr);
        decode_t           d;
        logic [ADDR_W-1:0] idx;
        logic [ADDR_W-1:0] rel;
        d.kind = REG_NONE;
        d.seg  = HOME_SEG;
        idx    = addr >> BYTE_SHIFT;
        rel    = idx - CTRL_INDEX_FIRST;
        if ((addr & ALIGN_MASK) != '0)
            d.kind = REG_NONE;
        else if (addr == CMD_ADDR)
            d.kind = REG_CMD;
        else if (addr == STATUS_ADDR)
            d.kind = REG_STATUS;
        else if (addr == TARGET_ADDR)
            d.kind = REG_TARGET;
        else if (idx >= CTRL_INDEX_FIRST && idx <= INDEX_LAST)
        begin
            d.seg = SEG_BITS'(rel >> BYTE_SHIFT) + SEG_STEP;
            if ((rel & ALIGN_MASK) == '0)
                d.kind = REG_CTRL;
            else if ((rel & ALIGN_MASK) == (VALUE_INDEX_FIRST - CTRL_INDEX_FIRST))
                d.kind = REG_VALUE;
        end
        return d;
    endfunction

    // Byte-lane merge of a written word into a stored one.
    function automatic logic [DATA_W-1:0] merge_strb(input logic [DATA_W-1:0] old_w,
                                                     input logic [DATA_W-1:0] new_w,
                                                     input logic [STRB_W-1:0] strb);
        logic [DATA_W-1:0] r;
        r = old_w;
        for (int b = 0; b < STRB_W; b++)
            if (strb[b])
                r[b*BYTE_W +: BYTE_W] = new_w[b*BYTE_W +: BYTE_W];
        return r;
    endfunction

    logic [DATA_W-1:0]   ctrl_mem  [0:SEG_COUNT];
    logic [DATA_W-1:0]   value_mem [0:SEG_COUNT];
    state_t              state_reg;
    state_t              state_next;
    logic [SEG_BITS-1:0] cur_seg_reg;
    logic [SEG_BITS-1:0] seg_next;
    logic [DATA_W-1:0]   cur_ctrl_reg;
    logic [DATA_W-1:0]   cur_value_reg;
    logic [DATA_W-1:0]   carry_reg;
    logic [SEG_BITS-1:0] cmd_seg_reg;
    logic [SEG_BITS-1:0] pend_seg_reg;
    logic                trig_level_reg;
    logic                trig_prev_reg;
    logic                pending_reg;
    logic                bvalid_reg;
    logic                rvalid_reg;
    logic [1:0]          bresp_reg;
    logic [1:0]          rresp_reg;
    logic [DATA_W-1:0]   rdata_reg;
    logic                wr_take;
    logic                rd_take;
    decode_t             wr_dec;
    decode_t             rd_dec;
    logic [DATA_W-1:0]   cmd_word;
    logic [DATA_W-1:0]   cmd_wr;
    logic [DATA_W-1:0]   status_word;
    logic [DATA_W-1:0]   rd_word;
    logic                stop_wr;
    logic                trig_edge;
    logic                take_pending;
    logic                intr_now;
    logic                pend_intr;
    logic [FIELD_W-1:0]  cur_type;
    logic [FIELD_W-1:0]  cur_cmd;
    logic [SEG_BITS-1:0] jump_seg;

    // Register bus handshakes: address and data are taken together.
    assign wr_take = awvalid && wvalid && !bvalid_reg;
    assign rd_take = arvalid && !rvalid_reg;
    assign awready = wr_take;
    assign wready  = wr_take;
    assign arready = !rvalid_reg;
    assign bvalid  = bvalid_reg;
    assign bresp   = bresp_reg;
    assign rvalid  = rvalid_reg;
    assign rresp   = rresp_reg;
    assign rdata   = rdata_reg;
    assign wr_dec  = decode(awaddr);
    assign rd_dec  = decode(araddr);
    assign cmd_wr  = merge_strb(cmd_word, wdata, wstrb);
    assign stop_wr = wr_take && wr_dec.kind == REG_CMD && cmd_wr[CMD_STOP_BIT];

    always_comb
    begin
        cmd_word = '0;
        cmd_word[CMD_SEG_LSB +: SEG_BITS] = cmd_seg_reg;
        cmd_word[CMD_TRIG_BIT] = trig_level_reg;
        status_word = '0;
        status_word[ST_BUSY_BIT] = busy;
        status_word[ST_IDLE_BIT] = state_reg == S_IDLE;
        status_word[ST_SEG_LSB +: SEG_BITS] = cur_seg_reg;
        status_word[ST_STATE_LSB +: $bits(state_t)] = state_reg;
        if (rd_dec.kind == REG_CMD)
            rd_word = cmd_word;
        else if (rd_dec.kind == REG_STATUS)
            rd_word = status_word;
        else if (rd_dec.kind == REG_TARGET)
            rd_word = target_position;
        else if (rd_dec.kind == REG_CTRL)
            rd_word = ctrl_mem[rd_dec.seg];
        else if (rd_dec.kind == REG_VALUE)
            rd_word = value_mem[rd_dec.seg];
        else
            rd_word = '0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end
        else if (wr_take)
        begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= (wr_dec.kind == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        else if (bready)
            bvalid_reg <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_reg <= 1'b0;
            rresp_reg  <= RESP_OKAY;
            rdata_reg  <= '0;
        end
        else if (rd_take)
        begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= (rd_dec.kind == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
            rdata_reg  <= rd_word;
        end
        else if (rready)
            rvalid_reg <= 1'b0;
    end

    // Segment table; every word clears at reset.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i <= SEG_COUNT; i++)
            begin
                ctrl_mem[i]  <= CTRL_RESET;
                value_mem[i] <= VALUE_RESET;
            end
        end
        else if (wr_take && wr_dec.kind == REG_CTRL)
            ctrl_mem[wr_dec.seg] <= merge_strb(ctrl_mem[wr_dec.seg], wdata, wstrb);
        else if (wr_take && wr_dec.kind == REG_VALUE)
            value_mem[wr_dec.seg] <= merge_strb(value_mem[wr_dec.seg], wdata, wstrb);
    end

    // Segment selection and trigger level; a trigger edge is held until taken or a stop is written.
    assign trig_edge = trig_level_reg && !trig_prev_reg;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cmd_seg_reg    <= HOME_SEG;
            trig_level_reg <= 1'b0;
            trig_prev_reg  <= 1'b0;
            pending_reg    <= 1'b0;
            pend_seg_reg   <= HOME_SEG;
        end
        else
        begin
            if (wr_take && wr_dec.kind == REG_CMD)
            begin
                cmd_seg_reg    <= cmd_wr[CMD_SEG_LSB +: SEG_BITS];
                trig_level_reg <= cmd_wr[CMD_TRIG_BIT];
            end
            trig_prev_reg <= trig_level_reg;
            if (trig_edge)
            begin
                pending_reg  <= 1'b1;
                pend_seg_reg <= cmd_seg_reg;
            end
            else if (take_pending || stop_wr)
                pending_reg <= 1'b0;
        end
    end

    // Field decode of the running segment and of a waiting request.
    assign cur_type  = cur_ctrl_reg[TYPE_LSB +: FIELD_W];
    assign cur_cmd   = cur_ctrl_reg[CMDTYPE_LSB +: FIELD_W];
    assign jump_seg  = cur_value_reg[SEG_BITS-1:0];
    assign pend_intr = ctrl_mem[pend_seg_reg][INTR_BIT] && pend_seg_reg != HOME_SEG;
    assign busy      = state_reg != S_IDLE;

    always_comb
    begin
        state_next   = state_reg;
        seg_next     = cur_seg_reg;
        take_pending = 1'b0;
        intr_now     = 1'b0;
        if (stop_wr)
            state_next = S_IDLE;
        else
            case (state_reg)
                S_IDLE:
                    if (pending_reg)
                    begin
                        take_pending = 1'b1;
                        seg_next     = pend_seg_reg;
                        state_next   = (pend_seg_reg == HOME_SEG) ? S_HOME : S_FETCH;
                    end
                S_FETCH:
                    state_next = S_EXEC;
                S_EXEC:
                    if (cur_type == SEG_JUMP)
                    begin
                        seg_next   = jump_seg;
                        state_next = (jump_seg == HOME_SEG) ? S_HOME : S_FETCH;
                    end
                    else if (cur_type == SEG_SPEED)
                        state_next = S_SPEED;
                    else
                        state_next = S_MOVE;
                S_MOVE:
                    if (pending_reg && (pend_intr || motion_done))
                    begin
                        take_pending = 1'b1;
                        intr_now     = !motion_done;
                        seg_next     = pend_seg_reg;
                        state_next   = (pend_seg_reg == HOME_SEG) ? S_HOME : S_FETCH;
                    end
                    else if (motion_done)
                    begin
                        if (cur_type == SEG_MULTI && cur_seg_reg != SEG_LAST)
                        begin
                            seg_next   = cur_seg_reg + SEG_STEP;
                            state_next = S_FETCH;
                        end
                        else
                            state_next = S_IDLE;
                    end
                S_SPEED:
                    if (pending_reg)
                    begin
                        take_pending = 1'b1;
                        seg_next     = pend_seg_reg;
                        state_next   = (pend_seg_reg == HOME_SEG) ? S_HOME : S_FETCH;
                    end
                    else if (cur_cmd == SPEED_CHAIN && speed_reached && cur_seg_reg != SEG_LAST)
                    begin
                        seg_next   = cur_seg_reg + SEG_STEP;
                        state_next = S_FETCH;
                    end
                S_HOME:
                    if (motion_done)
                        state_next = S_IDLE;
                default:
                    state_next = S_IDLE;
            endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg   <= S_IDLE;
            cur_seg_reg <= HOME_SEG;
        end
        else
        begin
            state_reg   <= state_next;
            cur_seg_reg <= seg_next;
        end
    end

    // Segment start: latch the stored entry, then plan the target.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cur_ctrl_reg     <= CTRL_RESET;
            cur_value_reg    <= VALUE_RESET;
            carry_reg        <= '0;
            target_position  <= '0;
            speed_value      <= '0;
            profile_select   <= '0;
            run_speed        <= 1'b0;
            segment_start    <= 1'b0;
            interrupt_switch <= 1'b0;
            home_request     <= 1'b0;
            stop_request     <= 1'b0;
        end
        else
        begin
            if (state_reg == S_FETCH)
            begin
                cur_ctrl_reg  <= ctrl_mem[cur_seg_reg];
                cur_value_reg <= value_mem[cur_seg_reg];
            end
            if (intr_now)
                carry_reg <= remaining_travel;
            else if (state_reg == S_EXEC)
                carry_reg <= '0;
            if (state_reg == S_EXEC && cur_type != SEG_JUMP)
            begin
                profile_select <= cur_ctrl_reg[PROFILE_LSB +: PROFILE_W];
                run_speed      <= cur_type == SEG_SPEED;
                if (cur_type == SEG_SPEED)
                    speed_value <= cur_value_reg;
                else if (cur_cmd == CMD_INC)
                    target_position <= target_position + cur_value_reg;
                else if (cur_cmd == CMD_REL)
                    target_position <= measured_position + cur_value_reg + carry_reg;
                else
                    target_position <= cur_value_reg;
            end
            segment_start    <= state_reg == S_EXEC && cur_type != SEG_JUMP;
            interrupt_switch <= intr_now;
            home_request     <= state_next == S_HOME && state_reg != S_HOME;
            stop_request     <= stop_wr;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_fetch_latch;
        state_reg == S_FETCH |=> cur_ctrl_reg == $past(ctrl_mem[cur_seg_reg]);
    endproperty
    a_fetch_latch: assert property (p_fetch_latch) else $error("entry not latched");

    property p_profile_sel;
        segment_start |-> profile_select == cur_ctrl_reg[PROFILE_LSB +: PROFILE_W];
    endproperty
    a_profile_sel: assert property (p_profile_sel) else $error("profile select wrong");

    property p_jump;
        state_reg == S_EXEC && cur_type == SEG_JUMP && !stop_wr && jump_seg != HOME_SEG
            |=> state_reg == S_FETCH && cur_seg_reg == $past(jump_seg);
    endproperty
    a_jump: assert property (p_jump) else $error("jump not taken");

    property p_single_stop;
        state_reg == S_MOVE && motion_done && !pending_reg && !stop_wr && cur_type == SEG_SINGLE
            |=> state_reg == S_IDLE && !segment_start;
    endproperty
    a_single_stop: assert property (p_single_stop) else $error("single kept going");

    property p_multi_chain;
        state_reg == S_MOVE && motion_done && !pending_reg && !stop_wr && cur_type == SEG_MULTI
            && cur_seg_reg != SEG_LAST |=> state_reg == S_FETCH
            && cur_seg_reg == $past(cur_seg_reg) + SEG_STEP
            ##1 (state_reg == S_EXEC || stop_request);
    endproperty
    a_multi_chain: assert property (p_multi_chain) else $error("multi did not chain");

    property p_speed_hold;
        state_reg == S_SPEED && !pending_reg && !stop_wr && cur_cmd == SPEED_HOLD
            |=> state_reg == S_SPEED;
    endproperty
    a_speed_hold: assert property (p_speed_hold) else $error("speed left early");

    property p_speed_chain;
        state_reg == S_SPEED && !pending_reg && !stop_wr && cur_cmd == SPEED_CHAIN
            && speed_reached && cur_seg_reg != SEG_LAST |=> state_reg == S_FETCH;
    endproperty
    a_speed_chain: assert property (p_speed_chain) else $error("speed did not chain");

    property p_abs;
        state_reg == S_EXEC && cur_type <= SEG_MULTI && cur_cmd == CMD_ABS
            |=> target_position == $past(cur_value_reg);
    endproperty
    a_abs: assert property (p_abs) else $error("absolute target wrong");

    property p_rel;
        state_reg == S_EXEC && cur_type <= SEG_MULTI && cur_cmd == CMD_REL
            |=> target_position == $past(measured_position) + $past(cur_value_reg)
            + $past(carry_reg);
    endproperty
    a_rel: assert property (p_rel) else $error("relative target wrong");

    property p_inc;
        state_reg == S_EXEC && cur_type <= SEG_MULTI && cur_cmd == CMD_INC
            |=> target_position == $past(target_position) + $past(cur_value_reg);
    endproperty
    a_inc: assert property (p_inc) else $error("incremental target wrong");

    property p_intr;
        state_reg == S_MOVE && pending_reg && pend_intr && !motion_done && !stop_wr
            |=> state_reg == S_FETCH && interrupt_switch && carry_reg == $past(remaining_travel);
    endproperty
    a_intr: assert property (p_intr) else $error("interrupt not taken");

    property p_no_intr;
        state_reg == S_MOVE && pending_reg && !pend_intr && !motion_done && !stop_wr
            |=> state_reg == S_MOVE && pending_reg;
    endproperty
    a_no_intr: assert property (p_no_intr) else $error("switched before done");

    property p_home;
        state_reg == S_IDLE && pending_reg && pend_seg_reg == HOME_SEG && !stop_wr
            |=> state_reg == S_HOME && home_request;
    endproperty
    a_home: assert property (p_home) else $error("home not requested");

    c_chain: cover property (state_reg == S_MOVE ##1 state_reg == S_FETCH);
    c_intr: cover property (interrupt_switch);
    c_jump: cover property (state_reg == S_EXEC && cur_type == SEG_JUMP);
    c_home: cover property (home_request);

endmodule

/* File: motion_profile_model.sv */
`timescale 1ns/1ps
module motion_profile_model
    import position_segment_sequencer_pkg::*;
#(
    parameter logic [DATA_W-1:0] MEAS = 32'h00012340,
    parameter int                DLY  = 40
)
(
    // Commands in.
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              segment_start,
    input  wire logic              home_request,
    input  wire logic              run_speed,
    // Feedback out.
    output logic [DATA_W-1:0]      measured_position,
    output logic [DATA_W-1:0]      remaining_travel,
    output logic                   motion_done,
    output logic                   speed_reached
);
    int cnt;
    always_ff @(posedge aclk)
        if (!aresetn || segment_start || home_request) cnt <= 0;
        else if (cnt < DLY) cnt <= cnt + 1;
    assign measured_position = MEAS;
    assign remaining_travel  = DATA_W'(DLY - cnt);
    assign motion_done       = !run_speed && cnt == DLY
                               && !segment_start && !home_request;
    assign speed_reached     = run_speed && cnt == DLY && !segment_start;
endmodule

/* File: position_segment_sequencer_tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; $display("CHECK FAILED %0t value mismatch", $time); end end
module position_segment_sequencer_tb;
    import position_segment_sequencer_pkg::*;
    localparam logic [DATA_W-1:0] MEAS = 32'h00012340;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [DATA_W-1:0] wdata = '0, rdv, rdata, measured_position, remaining_travel;
    logic [DATA_W-1:0] target_position, speed_value, v [10];
    logic [STRB_W-1:0] wstrb = '0;
    logic [1:0] rsp, bresp, rresp;
    logic [15:0] p, profile_select;
    logic awready, wready, bvalid, arready, rvalid, run_speed, segment_start, interrupt_switch;
    logic home_request, stop_request, busy, motion_done, speed_reached, isw, stp;
    int err_count = 0, n_checks = 0, cycles = 0, c;
    position_segment_sequencer DUT (.*, .awprot(3'h0), .arprot(3'h0));
    motion_profile_model #(.MEAS(MEAS)) PM (.*);
    always #10 aclk = ~aclk;
    always @(posedge aclk) if (++cycles == 5000) begin err_count++; final_report; end
    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    function automatic logic [ADDR_W-1:0] adr(int n, logic [ADDR_W-1:0] f);
        return (f + ADDR_W'(4 * (n - 1))) << BYTE_SHIFT;
    endfunction
    function automatic logic [DATA_W-1:0] ctl(logic [3:0] ty, logic [3:0] cm, logic it);
        return {p, 7'h00, it, cm, ty};
    endfunction
    function automatic logic [DATA_W-1:0] tgt(logic [3:0] cm, logic [DATA_W-1:0] pv, vl);
        return cm == CMD_INC ? pv + vl : cm == CMD_REL ? MEAS + vl : vl;
    endfunction
    task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
        awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1; wvalid <= 1; bready <= 1;
        do @(posedge aclk); while (!(awready && wready));
        awvalid <= 0; wvalid <= 0;
        do @(posedge aclk); while (!bvalid);
        rsp = bresp; stp = stop_request; bready <= 0;
        @(posedge aclk);
    endtask
    task automatic rd(logic [ADDR_W-1:0] a);
        araddr <= a; arvalid <= 1; rready <= 1;
        do @(posedge aclk); while (!arready);
        arvalid <= 0;
        do @(posedge aclk); while (!rvalid);
        rdv = rdata; rsp = rresp; rready <= 0;
        @(posedge aclk);
    endtask
    task automatic seg(int n, logic [DATA_W-1:0] w);
        wr(adr(n, CTRL_INDEX_FIRST), w);
        wr(adr(n, VALUE_INDEX_FIRST), v[n]);
    endtask
    task automatic trig(int n);
        wr(CMD_ADDR, DATA_W'(n));
        wr(CMD_ADDR, DATA_W'(n) | 32'h00000100);
    endtask
    task automatic ws;
        c = 0;
        isw = 0;
        do begin @(posedge aclk); c++; isw |= interrupt_switch; end
        while (segment_start !== 1'b1 && c < 300);
    endtask
    task automatic idle;
        while (busy !== 1'b0) @(posedge aclk);
    endtask
    initial begin
        void'($urandom(77));
        foreach (v[i]) v[i] = $urandom();
        v[3] = 32'h00000004;
        p = 16'($urandom_range(16'h7fff));
        repeat (16) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rd(adr(1 + $urandom_range(30), CTRL_INDEX_FIRST));
        `CHK(rdv, CTRL_RESET)
        rd(16'h1000);
        `CHK(rsp, RESP_SLVERR)
        wr(16'h1000, v[0]);
        `CHK(rsp, RESP_SLVERR)
        seg(1, ctl(SEG_MULTI, CMD_INC, 0));
        seg(2, ctl(SEG_SINGLE, CMD_REL, 0));
        trig(1);
        ws;
        `CHK(target_position, tgt(CMD_INC, 0, v[1]))
        `CHK(profile_select, p)
        ws;
        `CHK(target_position, tgt(CMD_REL, 0, v[2]))
        ws;
        `CHK(c, 300)
        seg(3, ctl(SEG_JUMP, CMD_ABS, 0));
        seg(4, ctl(SEG_SINGLE, CMD_ABS, 0));
        trig(3);
        ws;
        `CHK(target_position, tgt(CMD_ABS, 0, v[4]))
        seg(5, ctl(SEG_SPEED, SPEED_CHAIN, 0));
        seg(6, ctl(SEG_SINGLE, CMD_ABS, 0));
        idle;
        trig(5);
        ws;
        `CHK({run_speed, speed_value}, {1'b1, v[5]})
        ws;
        `CHK({run_speed, target_position}, {1'b0, v[6]})
        for (int i = 7; i < 10; i++) seg(i, ctl(SEG_SINGLE, CMD_ABS, i == 8));
        idle;
        trig(7);
        ws;
        trig(8);
        ws;
        `CHK({c < 20, isw, target_position}, {1'b1, 1'b1, v[8]})
        trig(9);
        ws;
        `CHK({c > 20, isw, target_position}, {1'b1, 1'b0, v[9]})
        idle;
        trig(0);
        c = 0;
        do begin @(posedge aclk); c++; end while (home_request !== 1'b1 && c < 20);
        `CHK({home_request, busy}, 2'b11)
        wr(CMD_ADDR, 32'h00000200);
        `CHK({busy, stp, rsp}, {1'b0, 1'b1, RESP_OKAY})
        final_report;
    end
endmodule
